/* rshc_ctrl.sv */
// strap decode, link enable, hot-plug low-time shutdown and snoop gating
// assumes straps stable at power-up; four-level pins arrive as 2-bit codes from the analog front end
`timescale 1ns/1ps
`include "rshc_params.svh"
module rshc_ctrl
  import rshc_pkg::*;
#(
  parameter int unsigned HPD_LOW_CYCLES = `RSHC_HPD_LOW_CYCLES
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  // four-level straps as codes
  input wire logic [1:0] mode_strap_in,
  input wire logic [1:0] eq_strap_high_in,
  input wire logic [1:0] eq_strap_low_in,
  input wire logic [1:0] addr_strap_low_in,
  // two-level pins
  input wire logic link_enable_pin_in,
  input wire logic hot_plug_input_in,
  input wire logic snoop_enable_bar_in,
  input wire logic aux_pair_pos_in,
  input wire logic aux_pair_neg_in,
  // two-wire register controls
  input wire logic reg_lanes_enable_in,
  input wire logic reg_snoop_enable_in,
  // outputs
  output logic [`RSHC_LANES-1:0] lane_enable_out,
  output logic snoop_active_out,
  output logic aux_snoop_bit_out,
  output logic [3:0] eq_gain_sel_out,
  output logic [3:0] twowire_addr_out,
  output logic twowire_port_on_out,
  output logic twowire_1v8_out,
  output logic test_mode_out,
  output logic straps_valid_out
);
  rshc_state_e state;
  rshc_state_e next_state;
  rshc_straps_s straps;
  rshc_straps_s strap_meta;
  rshc_straps_s strap_sync;
  logic [3:0] latch_cnt;
  logic [1:0] link_en_sync, hpd_shared_sync, hpd_ded_sync, snoop_sync, aux_pair_pos_sync, aux_pair_neg_sync;
  logic [22:0] low_cnt;
  logic hpd_timeout;
  logic [`RSHC_LANES-1:0] next_lanes;

  // two-stage synchronisers for pins, straps included
  // shared pin feeds two synchronisers; each mode reads only one of them
  always_ff @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      link_en_sync <= 2'h0;
      hpd_shared_sync <= 2'h0;
      hpd_ded_sync <= 2'h0;
      snoop_sync <= 2'h0;
      aux_pair_pos_sync <= 2'h0;
      aux_pair_neg_sync <= 2'h0;
      strap_meta <= '0;
      strap_sync <= '0;
    end
    else
    begin
      link_en_sync <= {link_en_sync[0], link_enable_pin_in};
      hpd_shared_sync <= {hpd_shared_sync[0], link_enable_pin_in};
      hpd_ded_sync <= {hpd_ded_sync[0], hot_plug_input_in};
      snoop_sync <= {snoop_sync[0], snoop_enable_bar_in};
      aux_pair_pos_sync <= {aux_pair_pos_sync[0], aux_pair_pos_in};
      aux_pair_neg_sync <= {aux_pair_neg_sync[0], aux_pair_neg_in};
      strap_meta <= {mode_strap_in, eq_strap_high_in, eq_strap_low_in, addr_strap_low_in};
      strap_sync <= strap_meta;
    end
  end

  // straps settle a few cycles after reset, then are frozen
  assign next_state = (state == RSHC_ST_WAIT) ? RSHC_ST_LATCH :
                      (state == RSHC_ST_LATCH && latch_cnt == `RSHC_LATCH_DELAY) ? RSHC_ST_RUN : state;

  always_ff @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      state <= RSHC_ST_WAIT;
      latch_cnt <= 4'h0;
      straps <= '0;
    end
    else
    begin
      state <= next_state;
      if (state == RSHC_ST_LATCH)
        latch_cnt <= latch_cnt + 4'h1;
      if (state == RSHC_ST_LATCH && latch_cnt == `RSHC_LATCH_DELAY)
        straps <= strap_sync;
    end
  end

  wire run = (state == RSHC_ST_RUN);
  rshc_mode_s mode;
  wire is_gpio = (straps.mode == `RSHC_LVL_LOW);
  assign mode.gpio_mode = is_gpio;
  assign mode.twowire_on = run && !is_gpio;
  assign mode.twowire_1v8 = (straps.mode == `RSHC_LVL_F);
  assign mode.test_mode = (straps.mode == `RSHC_LVL_R);

  // shared pin is hot-plug in two-wire mode, dedicated pin in pin mode
  wire hpd_level = mode.gpio_mode ? hpd_ded_sync[1] : hpd_shared_sync[1];
  wire base_enable = mode.gpio_mode ? link_en_sync[1] : reg_lanes_enable_in;
  wire snoop_want = mode.gpio_mode ? !snoop_sync[1] : reg_snoop_enable_in;

  // low-time counter saturates; restarts on any high sample
  always_ff @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      low_cnt <= 23'h0;
    else if (hpd_level)
      low_cnt <= 23'h0;
    else if (!hpd_timeout)
      low_cnt <= low_cnt + 23'h1;
  end
  assign hpd_timeout = (low_cnt >= HPD_LOW_CYCLES[22:0]);

  // snoop disabled in pin mode keeps all lanes active while the enable pin is high, regardless of hot-plug
  wire hpd_gate = (mode.gpio_mode && !snoop_want) ? 1'b1 : !hpd_timeout;
  assign next_lanes = {`RSHC_LANES{run && base_enable && hpd_gate}};

  always_ff @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      lane_enable_out <= '0;
      snoop_active_out <= 1'b0;
      aux_snoop_bit_out <= 1'b0;
      eq_gain_sel_out <= 4'h0;
      twowire_addr_out <= 4'h0;
      twowire_port_on_out <= 1'b0;
      twowire_1v8_out <= 1'b0;
      test_mode_out <= 1'b0;
      straps_valid_out <= 1'b0;
    end
    else
    begin
      lane_enable_out <= next_lanes;
      snoop_active_out <= run && snoop_want;
      // receive-only: the aux pair is never driven here
      aux_snoop_bit_out <= run && snoop_want && aux_pair_pos_sync[1] && !aux_pair_neg_sync[1];
      eq_gain_sel_out <= {straps.eq_high, straps.eq_low};
      twowire_addr_out <= mode.twowire_on ? {straps.eq_low, straps.addr_low} : 4'h0;
      twowire_port_on_out <= mode.twowire_on;
      twowire_1v8_out <= mode.twowire_on && mode.twowire_1v8;
      test_mode_out <= mode.twowire_on && mode.test_mode;
      straps_valid_out <= run;
    end
  end

  // assertions
  // unsaturated twin of low_cnt, so the timeout check does not lean on it
  int unsigned lo_run;
  always_ff @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      lo_run <= 0;
    else
      lo_run <= hpd_level ? 0 : lo_run + 1;
  end

  gpio_lane_off_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    (run && mode.gpio_mode && !link_en_sync[1]) |=> (lane_enable_out == '0))
    else $error("lanes on while enable pin low");
  twowire_port_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    run |=> (twowire_port_on_out == (straps.mode != `RSHC_LVL_LOW)))
    else $error("two-wire port state wrong");
  hpd_timeout_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    (lo_run > HPD_LOW_CYCLES + 1 && !(mode.gpio_mode && snoop_sync[1])) |-> (lane_enable_out == '0))
    else $error("lanes on after long hot-plug low");
  hpd_restart_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    hpd_level |=> (low_cnt == 23'h0))
    else $error("low counter not restarted");
  reg_enable_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    (run && !mode.gpio_mode && !reg_lanes_enable_in) |=> (lane_enable_out == '0))
    else $error("lanes on with register enable clear");
  snoop_pin_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    (run && mode.gpio_mode) |=> (snoop_active_out == !$past(snoop_sync[1])))
    else $error("snoop state does not follow pin");
  eq_sel_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    run |=> (eq_gain_sel_out == {straps.eq_high, straps.eq_low}))
    else $error("eq selection mismatch");
  addr_sel_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    $rose(straps_valid_out) |-> ##[0:2] (twowire_addr_out == (mode.gpio_mode ? 4'h0 : {straps.eq_low, straps.addr_low})))
    else $error("address mismatch");
  straps_frozen_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    run |=> $stable(straps))
    else $error("straps changed after latch");
  ded_pin_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    (mode.gpio_mode && hpd_ded_sync[1]) |=> (low_cnt == 23'h0))
    else $error("dedicated hot-plug ignored");
  aux_passive_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    aux_snoop_bit_out |-> snoop_active_out)
    else $error("aux sampled without snoop");
  lane_on_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    (run && mode.gpio_mode && link_en_sync[1] && !hpd_timeout) |=> (lane_enable_out == '1))
    else $error("lanes off while enable pin high");
  snoop_keep_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    (run && mode.gpio_mode && snoop_sync[1] && link_en_sync[1]) |=> (lane_enable_out == '1))
    else $error("lanes dropped with snoop disabled");
  ded_ignored_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    (run && !mode.gpio_mode && hpd_shared_sync[1] && !hpd_ded_sync[1]) |=> (low_cnt == 23'h0))
    else $error("reserved hot-plug pin used in two-wire mode");

  lanes_up_c: cover property (@(posedge clk_sys_in) disable iff (!arst_n_in) $rose(lane_enable_out[0]));
  hpd_drop_c: cover property (@(posedge clk_sys_in) disable iff (!arst_n_in) $rose(hpd_timeout));
  twowire_c: cover property (@(posedge clk_sys_in) disable iff (!arst_n_in) $rose(twowire_port_on_out));
  snoop_c: cover property (@(posedge clk_sys_in) disable iff (!arst_n_in) $rose(snoop_active_out));
  hpd_back_c: cover property (@(posedge clk_sys_in) disable iff (!arst_n_in) $fell(hpd_timeout));
endmodule : rshc_ctrl

/* rshc_ctrl_tb_top.sv */
// self-checking bench for rshc_ctrl with a shortened hot-plug low time
// assumes straps are re-latched only by a reset
`timescale 1ns/1ps
module rshc_ctrl_tb_top;
  import rshc_pkg::*;
  localparam int unsigned LOW_CYC = 20;
  logic clk_sys_in = 1'b0;
  logic arst_n_in = 1'b0;
  rshc_straps_s straps = '0;
  logic link_en = 1'b1, snoop_bar = 1'b1, reg_lanes = 1'b0, reg_snoop = 1'b0, plug_req = 1'b1, aux_req = 1'b0;
  logic hot_plug, aux_pos, aux_neg, snoop_act, aux_bit, port_on, v18, test_mode, valid;
  logic tw_clk, tw_data;
  logic [3:0] lanes, eq_gain, addr;
  int err_count = 0, checked = 0, cycles = 0;
  rshc_far_model far (.clk_in(clk_sys_in), .plug_req_in(plug_req), .aux_req_in(aux_req),
    .pin_mode_in(straps.mode == 2'h0), .hot_plug_out(hot_plug), .aux_pos_out(aux_pos), .aux_neg_out(aux_neg),
    .test_strap_one_out(tw_clk), .test_strap_two_out(tw_data));
  rshc_ctrl #(.HPD_LOW_CYCLES(LOW_CYC)) uut (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
    .mode_strap_in(straps.mode), .eq_strap_high_in(straps.eq_high), .eq_strap_low_in(straps.eq_low),
    .addr_strap_low_in(straps.addr_low), .link_enable_pin_in(link_en), .hot_plug_input_in(hot_plug),
    .snoop_enable_bar_in(snoop_bar), .aux_pair_pos_in(aux_pos), .aux_pair_neg_in(aux_neg),
    .reg_lanes_enable_in(reg_lanes), .reg_snoop_enable_in(reg_snoop), .lane_enable_out(lanes),
    .snoop_active_out(snoop_act), .aux_snoop_bit_out(aux_bit), .eq_gain_sel_out(eq_gain),
    .twowire_addr_out(addr), .twowire_port_on_out(port_on), .twowire_1v8_out(v18),
    .test_mode_out(test_mode), .straps_valid_out(valid));
  initial
  begin
    forever #20 clk_sys_in = ~clk_sys_in;
  end
  task automatic report_and_stop();
    $display("mismatches %0d of %0d compares", err_count, checked);
    if (err_count == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop
  always @(posedge clk_sys_in)
  begin
    cycles++;
    // whole run needs well under 1500 cycles
    if (cycles == 5000)
    begin
      err_count++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask : wt
  task automatic pin_tests();
    link_en = 1'b0; wt(5); chk(8'(lanes), 8'h00);
    link_en = 1'b1; wt(5); chk(8'(lanes), 8'h0f);
    snoop_bar = 1'b0; aux_req = 1'b1; reg_lanes = 1'b0; wt(5);
    chk(8'({snoop_act, aux_bit, lanes}), 8'h3f);
    plug_req = 1'b0; wt(15); chk(8'(lanes), 8'h0f);
    plug_req = 1'b1; wt(5); plug_req = 1'b0; wt(15); chk(8'(lanes), 8'h0f);
    wt(15); chk(8'(lanes), 8'h00);
    plug_req = 1'b1; wt(6); chk(8'(lanes), 8'h0f);
    snoop_bar = 1'b1; plug_req = 1'b0; wt(40); chk(8'({snoop_act, lanes}), 8'h0f);
    plug_req = 1'b1;
  endtask : pin_tests
  task automatic wire_tests();
    reg_lanes = 1'b1; reg_snoop = 1'b1; wt(5); chk(8'({snoop_act, lanes}), 8'h1f);
    reg_lanes = 1'b0; wt(4); chk(8'(lanes), 8'h00);
    reg_lanes = 1'b1; plug_req = 1'b0; wt(40); chk(8'(lanes), 8'h0f);
    link_en = 1'b0; wt(40); chk(8'(lanes), 8'h00);
    link_en = 1'b1; wt(6); chk(8'(lanes), 8'h0f);
    plug_req = 1'b1;
  endtask : wire_tests
  initial
  begin
    for (int m = 0; m < 4; m++)
    begin
      arst_n_in = 1'b0;
      // float on the low address strap reads as F, legal in every mode
      straps = '{mode: 2'(m), eq_high: 2'(3 - m), eq_low: 2'(m), addr_low: (m % 2) ? 2'h1 : 2'h2};
      wt(5);
      arst_n_in = 1'b1;
      wt(16);
      chk(8'({port_on, v18, test_mode, valid}), {4'h0, m != 0, m == 2, m == 1, 1'b1});
      chk(8'({tw_clk, tw_data}), (m != 0) ? 8'h03 : 8'h00);
      chk(8'(eq_gain), {4'h0, 2'(3 - m), 2'(m)});
      chk(8'(addr), (m != 0) ? {4'h0, 2'(m), straps.addr_low} : 8'h00);
      if (m == 0)
        pin_tests();
      if (m == 3)
        wire_tests();
    end
    report_and_stop();
  end
endmodule : rshc_ctrl_tb_top

/* rshc_far_model.sv */
// far side stand-in: display sink hot-plug level and aux pair levels
// assumes the bench commands it on the falling edge; it moves on the rising edge, after the block samples
`timescale 1ns/1ps
module rshc_far_model (
  // clock
  input wire logic clk_in,
  // commands from the bench
  input wire logic plug_req_in,
  input wire logic aux_req_in,
  input wire logic pin_mode_in,
  // sink-side lines
  output logic hot_plug_out,
  output logic aux_pos_out,
  output logic aux_neg_out,
  // host two-wire lines
  output logic test_strap_one_out,
  output logic test_strap_two_out
);
  // pin mode: host grounds both lines; otherwise they idle high on pull-ups
  assign test_strap_one_out = !pin_mode_in;
  assign test_strap_two_out = !pin_mode_in;
  initial
  begin
    hot_plug_out = 1'b1;
    aux_pos_out = 1'b0;
    aux_neg_out = 1'b1;
  end
  always @(posedge clk_in)
  begin
    hot_plug_out <= plug_req_in;
    // pair always complementary, never both equal
    aux_pos_out <= aux_req_in;
    aux_neg_out <= ~aux_req_in;
  end
endmodule : rshc_far_model

/* rshc_params.svh */
// constants for the redriver strap and hot-plug control block
// assumes a 25 MHz system clock
`ifndef RSHC_PARAMS_SVH
`define RSHC_PARAMS_SVH
`define RSHC_CLK_HZ 25_000_000
`define RSHC_HPD_LOW_TIME_US 2000
`define RSHC_HPD_LOW_CYCLES ((`RSHC_CLK_HZ / 1_000_000) * `RSHC_HPD_LOW_TIME_US)
`define RSHC_LANES 4
`define RSHC_LVL_LOW 2'h0
`define RSHC_LVL_R 2'h1
`define RSHC_LVL_F 2'h2
`define RSHC_LVL_HIGH 2'h3
`define RSHC_LATCH_DELAY 4'h8
`endif

/* rshc_pkg.sv */
// types for the redriver strap and hot-plug control block
// assumes rshc_params.svh defines the level codes
package rshc_pkg;
  typedef enum logic [1:0] {
    RSHC_ST_WAIT = 2'b00,
    RSHC_ST_LATCH = 2'b01,
    RSHC_ST_RUN = 2'b11
  } rshc_state_e;

  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] eq_high;
    logic [1:0] eq_low;
    logic [1:0] addr_low;
  } rshc_straps_s;

  typedef struct packed {
    logic gpio_mode;
    logic twowire_on;
    logic twowire_1v8;
    logic test_mode;
  } rshc_mode_s;
endpackage : rshc_pkg
